// ==== verilog/sigmon_regs.sv ====
// register bank for sync gating, fast detect and signal monitor
module sigmon_regs (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// register port from the serial control block
	input  wire logic [8:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic [7:0]       reg_rdata_o,
	// external sync pin
	input  wire logic        sync_pin_i,
	output logic             mon_sync_o,
	output logic             div_sync_o,
	// measurement results from the monitor core
	input  wire logic [19:0] result_a_i,
	input  wire logic [19:0] result_b_i,
	input  wire logic [13:0] dc_a_i,
	input  wire logic [13:0] dc_b_i,
	// fast detect data and channel state
	input  wire logic        lvds_mode_i,
	input  wire logic        fd_interleave_i,
	input  wire logic        chan_a_off_i,
	input  wire logic        chan_b_off_i,
	input  wire logic [3:0]  fd_a_i,
	input  wire logic [3:0]  fd_b_i,
	output logic [3:0]       fd_a_o,
	output logic [3:0]       fd_b_o,
	output logic             fd_oe_n_o,
	// decoded configuration
	output logic [2:0]       fd_mode_o,
	output logic [2:0]       coarse_code_o,
	output logic [23:0]      period_o,
	output logic             mon_en_o,
	output sigmon_regs_pkg::mon_mode_t mon_mode_o,
	output logic             mon_ms_o,
	output logic             mon_cplx_o,
	output logic [3:0]       ser_out_en_o,
	output logic             ser_sleep_o,
	output logic [3:0]       ser_div_o
);
	logic [7:0]  sync_q;
	logic [7:0]  fd_q;
	logic [7:0]  coarse_q;
	logic [7:0]  ser_q;
	logic [7:0]  mon_q;
	logic [7:0]  per_lo_q;
	logic [7:0]  per_mid_q;
	logic [7:0]  per_hi_q;
	logic [23:0] period_q;
	logic [3:0]  ser_div_q;
	logic [3:0]  fd_a_d;
	logic [3:0]  fd_a_q;
	logic [3:0]  fd_b_d;
	logic [3:0]  fd_b_q;
	logic        fd_oe_n_d;
	logic        fd_oe_n_q;
	logic [1:0]  sync_pin_q;
	logic        div_clear;
	logic        wr_sync;
	logic        wr_fd;
	logic        wr_coarse;
	logic        wr_ser;
	logic        wr_mon;
	logic        wr_per_lo;
	logic        wr_per_mid;
	logic        wr_per_hi;

	// write strobe for one offset; read-only offsets never get one
	function automatic logic wr_hit(input logic wr, input logic [8:0] a,
		input logic [8:0] target);
		return wr && (a == target);
	endfunction : wr_hit

	// serial bit clock ratio; code 00 is undefined, treated as 2
	function automatic logic [3:0] div_ratio(input logic [1:0] code);
		logic [3:0] r;
		case (code)
			2'b10:   r = 4'h4;
			2'b11:   r = 4'h8;
			default: r = 4'h2;
		endcase
		return r;
	endfunction : div_ratio

	// read-data helper: selects byte idx of a result value
	function automatic logic [7:0] bytesel(input logic [19:0] v,
		input int idx);
		logic [7:0] r;
		r = 8'h00;
		r = v[idx*8 +: 8];
		return r;
	endfunction : bytesel

	// two stage synchroniser for the asynchronous sync pin
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_pin_q <= 2'b00;
		end else begin
			sync_pin_q <= {sync_pin_q[0], sync_pin_i};
		end
	end

	sigmon_sync_gate u_gate (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.sync_lvl_i  (sync_pin_q[1]),
		.master_en_i (sync_q[sigmon_regs_pkg::SYNC_MASTER_BIT]),
		.mon_en_i    (sync_q[sigmon_regs_pkg::SYNC_MON_BIT]),
		.div_en_i    (sync_q[sigmon_regs_pkg::SYNC_DIV_BIT]),
		.oneshot_i   (sync_q[sigmon_regs_pkg::SYNC_ONESHOT_BIT]),
		.mon_sync_o  (mon_sync_o),
		.div_sync_o  (div_sync_o),
		.div_clear_o (div_clear)
	);

	// one write strobe per writable register
	assign wr_sync    = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_SYNC);
	assign wr_fd      = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_FD_CTRL);
	assign wr_coarse  = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_COARSE);
	assign wr_ser     = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_SER_CTRL);
	assign wr_mon     = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_MON_CTRL);
	assign wr_per_lo  = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_PERIOD0);
	assign wr_per_mid = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_PERIOD1);
	assign wr_per_hi  = wr_hit(reg_wr_i, reg_addr_i,
		sigmon_regs_pkg::ADDR_PERIOD2);

	// sync control; hardware clear wins over a same-cycle write of bit 1
	// since the sync has already been consumed
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_q <= sigmon_regs_pkg::SYNC_RST;
		end else begin
			if (wr_sync) begin
				sync_q <= reg_wdata_i & sigmon_regs_pkg::SYNC_WMASK;
			end
			if (div_clear) begin
				sync_q[sigmon_regs_pkg::SYNC_DIV_BIT] <= 1'b0;
			end
		end
	end

	// fast detect control; reserved bits read back as zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fd_q <= sigmon_regs_pkg::FD_RST;
		end else if (wr_fd) begin
			fd_q <= reg_wdata_i & sigmon_regs_pkg::FD_WMASK;
		end
	end

	// coarse threshold code
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			coarse_q <= sigmon_regs_pkg::COARSE_RST;
		end else if (wr_coarse) begin
			coarse_q <= reg_wdata_i & sigmon_regs_pkg::COARSE_WMASK;
		end
	end

	// serial output control; the ratio is decoded once on the write
	// so the bit clock divider never sees a half-decoded code
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ser_q     <= sigmon_regs_pkg::SER_RST;
			ser_div_q <= div_ratio(2'(sigmon_regs_pkg::SER_RST >>
				sigmon_regs_pkg::SER_DIV_LSB));
		end else if (wr_ser) begin
			ser_q     <= reg_wdata_i & sigmon_regs_pkg::SER_WMASK;
			ser_div_q <= div_ratio(
				reg_wdata_i[sigmon_regs_pkg::SER_DIV_LSB +: 2]);
		end
	end

	// monitor control
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mon_q <= sigmon_regs_pkg::MON_RST;
		end else if (wr_mon) begin
			mon_q <= reg_wdata_i & sigmon_regs_pkg::MON_WMASK;
		end
	end

	// period low byte; reset value is below the useful minimum
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			per_lo_q <= 8'(sigmon_regs_pkg::PERIOD_RST);
		end else if (wr_per_lo) begin
			per_lo_q <= reg_wdata_i;
		end
	end

	// period middle byte; no latching across the bytes
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			per_mid_q <= 8'(sigmon_regs_pkg::PERIOD_RST >> 8);
		end else if (wr_per_mid) begin
			per_mid_q <= reg_wdata_i;
		end
	end

	// period high byte
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			per_hi_q <= 8'(sigmon_regs_pkg::PERIOD_RST >> 16);
		end else if (wr_per_hi) begin
			per_hi_q <= reg_wdata_i;
		end
	end
	assign period_q = {per_hi_q, per_mid_q, per_lo_q};

	// read mux; results and dc values come straight from the core
	always_comb begin
		case (reg_addr_i)
			sigmon_regs_pkg::ADDR_SYNC:     reg_rdata_o = sync_q;
			sigmon_regs_pkg::ADDR_FD_CTRL:  reg_rdata_o = fd_q;
			sigmon_regs_pkg::ADDR_COARSE:   reg_rdata_o = coarse_q;
			sigmon_regs_pkg::ADDR_DC_A_LO:  reg_rdata_o = dc_a_i[7:0];
			sigmon_regs_pkg::ADDR_DC_A_HI:
				reg_rdata_o = {2'b00, dc_a_i[13:8]};
			sigmon_regs_pkg::ADDR_DC_B_LO:  reg_rdata_o = dc_b_i[7:0];
			sigmon_regs_pkg::ADDR_DC_B_HI:
				reg_rdata_o = {2'b00, dc_b_i[13:8]};
			sigmon_regs_pkg::ADDR_SER_CTRL: reg_rdata_o = ser_q;
			sigmon_regs_pkg::ADDR_MON_CTRL: reg_rdata_o = mon_q;
			sigmon_regs_pkg::ADDR_PERIOD0:  reg_rdata_o = period_q[7:0];
			sigmon_regs_pkg::ADDR_PERIOD1:  reg_rdata_o = period_q[15:8];
			sigmon_regs_pkg::ADDR_PERIOD2:  reg_rdata_o = period_q[23:16];
			sigmon_regs_pkg::ADDR_RES_A0:   reg_rdata_o = bytesel(result_a_i, 0);
			sigmon_regs_pkg::ADDR_RES_A1:   reg_rdata_o = bytesel(result_a_i, 1);
			sigmon_regs_pkg::ADDR_RES_A2:
				reg_rdata_o = {4'h0, result_a_i[19:16]};
			sigmon_regs_pkg::ADDR_RES_B0:   reg_rdata_o = bytesel(result_b_i, 0);
			sigmon_regs_pkg::ADDR_RES_B1:   reg_rdata_o = bytesel(result_b_i, 1);
			sigmon_regs_pkg::ADDR_RES_B2:
				reg_rdata_o = {4'h0, result_b_i[19:16]};
			default:                        reg_rdata_o = 8'h00;
		endcase
	end

	// next pin state; oe is active low like the other drivers
	always_comb begin
		fd_a_d    = fd_a_i;
		fd_b_d    = fd_b_i;
		fd_oe_n_d = ~fd_q[sigmon_regs_pkg::FD_EN_BIT];
		if (lvds_mode_i && fd_interleave_i) begin
			if (chan_a_off_i && chan_b_off_i) begin
				fd_oe_n_d = 1'b1;
			end else if (chan_a_off_i) begin
				fd_a_d = fd_b_i;
			end else if (chan_b_off_i) begin
				fd_b_d = fd_a_i;
			end
		end
	end

	// pins from flops so a channel going to sleep cannot glitch them;
	// the price is one cycle of latency on the fast detect path
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fd_a_q    <= 4'h0;
			fd_b_q    <= 4'h0;
			fd_oe_n_q <= 1'b1;
		end else begin
			fd_a_q    <= fd_a_d;
			fd_b_q    <= fd_b_d;
			fd_oe_n_q <= fd_oe_n_d;
		end
	end
	assign fd_a_o    = fd_a_q;
	assign fd_b_o    = fd_b_q;
	assign fd_oe_n_o = fd_oe_n_q;

	// decoded configuration fields for the monitor core
	assign fd_mode_o     = fd_q[sigmon_regs_pkg::FD_MODE_LSB +: 3];
	assign coarse_code_o = coarse_q[2:0];
	assign period_o      = period_q;
	assign mon_en_o      = mon_q[sigmon_regs_pkg::MON_EN_BIT];
	assign mon_mode_o    = sigmon_regs_pkg::mon_mode_t'(
		mon_q[sigmon_regs_pkg::MON_MODE_LSB +: 2]);
	assign mon_ms_o      = mon_q[sigmon_regs_pkg::MON_MS_BIT];
	assign mon_cplx_o    = mon_q[sigmon_regs_pkg::MON_CPLX_BIT];
	assign ser_out_en_o  = {ser_q[6:4], ser_q[sigmon_regs_pkg::SER_EN_BIT]};
	assign ser_sleep_o   = ser_q[sigmon_regs_pkg::SER_SLEEP_BIT];
	assign ser_div_o     = ser_div_q;
endmodule : sigmon_regs

// ==== verilog/sigmon_regs_pkg.sv ====
// Behaviour
// - monitor sync needs bits 7 and 0
// - divider sync needs bits 1 and 0
// - one-shot: divider takes first sync only
// - divider sync gate clears itself after sync in one-shot only
// - master bit clear disables all sync
// - fast detect mode from control bits 3:1
// - fast detect disabled: pins high impedance
// - interleaved lvds floats only both channels off
// - interleaved lvds one off: repeat active data
// - coarse threshold code in bits 2:0
// - 24-bit period, low byte resets 0x40
// - read-only 20-bit result per channel
// - monitor mode 00 rms, 01 peak, 1x crossing
// - power select: 0 rms, 1 ms
package sigmon_regs_pkg;
	localparam logic [8:0] ADDR_SYNC      = 9'h100;
	localparam logic [8:0] ADDR_FD_CTRL   = 9'h104;
	localparam logic [8:0] ADDR_COARSE    = 9'h105;
	localparam logic [8:0] ADDR_DC_A_LO   = 9'h10d;
	localparam logic [8:0] ADDR_DC_A_HI   = 9'h10e;
	localparam logic [8:0] ADDR_DC_B_LO   = 9'h10f;
	localparam logic [8:0] ADDR_DC_B_HI   = 9'h110;
	localparam logic [8:0] ADDR_SER_CTRL  = 9'h111;
	localparam logic [8:0] ADDR_MON_CTRL  = 9'h112;
	localparam logic [8:0] ADDR_PERIOD0   = 9'h113;
	localparam logic [8:0] ADDR_PERIOD1   = 9'h114;
	localparam logic [8:0] ADDR_PERIOD2   = 9'h115;
	localparam logic [8:0] ADDR_RES_A0    = 9'h116;
	localparam logic [8:0] ADDR_RES_A1    = 9'h117;
	localparam logic [8:0] ADDR_RES_A2    = 9'h118;
	localparam logic [8:0] ADDR_RES_B0    = 9'h119;
	localparam logic [8:0] ADDR_RES_B1    = 9'h11a;
	localparam logic [8:0] ADDR_RES_B2    = 9'h11b;
	// sync control fields
	localparam int SYNC_MASTER_BIT  = 0;
	localparam int SYNC_DIV_BIT     = 1;
	localparam int SYNC_ONESHOT_BIT = 2;
	localparam int SYNC_MON_BIT     = 7;
	localparam logic [7:0] SYNC_WMASK = 8'h87;
	// fast detect control fields
	localparam int FD_EN_BIT   = 0;
	localparam int FD_MODE_LSB = 1;
	localparam logic [7:0] FD_WMASK    = 8'h0f;
	localparam logic [7:0] COARSE_WMASK = 8'h07;
	// serial output control fields
	localparam int SER_EN_BIT    = 0;
	localparam int SER_SLEEP_BIT = 1;
	localparam int SER_DIV_LSB   = 2;
	localparam logic [7:0] SER_WMASK = 8'h7f;
	// monitor control fields
	localparam int MON_EN_BIT   = 0;
	localparam int MON_MODE_LSB = 1;
	localparam int MON_MS_BIT   = 3;
	localparam int MON_CPLX_BIT = 7;
	localparam logic [7:0] MON_WMASK = 8'h8f;
	// reset values
	localparam logic [7:0] SYNC_RST    = 8'h00;
	localparam logic [7:0] FD_RST      = 8'h00;
	localparam logic [7:0] COARSE_RST  = 8'h00;
	localparam logic [7:0] SER_RST     = 8'h04;
	localparam logic [7:0] MON_RST     = 8'h00;
	localparam logic [23:0] PERIOD_RST = 24'h000040;
	localparam logic [23:0] PERIOD_MIN = 24'h000080;
	// widths
	localparam int RES_W  = 20;
	localparam int DC_W   = 14;
	localparam int FD_W   = 4;
	typedef enum logic [1:0] {
		MODE_RMS, MODE_PEAK, MODE_CROSS_A, MODE_CROSS_B
	} mon_mode_t;
endpackage : sigmon_regs_pkg

// ==== verilog/sigmon_sync_gate.sv ====
// sync pulse gating for the monitor and the input clock divider
module sigmon_sync_gate (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// synchronised sync level and gate bits
	input  wire logic       sync_lvl_i,
	input  wire logic       master_en_i,
	input  wire logic       mon_en_i,
	input  wire logic       div_en_i,
	input  wire logic       oneshot_i,
	// gated pulses
	output logic            mon_sync_o,
	output logic            div_sync_o,
	output logic            div_clear_o
);
	logic sync_prev_q;
	logic sync_edge;

	// rising edge of the already synchronised sync level
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_prev_q <= 1'b0;
		end else begin
			sync_prev_q <= sync_lvl_i;
		end
	end
	assign sync_edge = sync_lvl_i & ~sync_prev_q;

	// master bit low kills both paths
	assign mon_sync_o  = sync_edge & mon_en_i & master_en_i;
	assign div_sync_o  = sync_edge & div_en_i & master_en_i;
	// one-shot: drop the gate so later pulses are blocked
	assign div_clear_o = div_sync_o & oneshot_i;
endmodule : sigmon_sync_gate

// ==== tb/sigmon_regs_checker.sv ====
// port-level rules of the register bank
module sigmon_regs_checker (
	// clock, reset and register port
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic [8:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic [7:0]  reg_rdata_o,
	// sync, core data and fast detect
	input wire logic        mon_sync_o,
	input wire logic        div_sync_o,
	input wire logic [19:0] result_a_i,
	input wire logic        lvds_mode_i,
	input wire logic        fd_interleave_i,
	input wire logic        chan_a_off_i,
	input wire logic        chan_b_off_i,
	input wire logic [3:0]  fd_b_i,
	input wire logic [3:0]  fd_a_o,
	input wire logic        fd_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// readback is only meaningful while the address is held
	wire logic sy = reg_addr_i == sigmon_regs_pkg::ADDR_SYNC;
	wire logic fs = reg_addr_i == sigmon_regs_pkg::ADDR_FD_CTRL;
	wire logic il = lvds_mode_i && fd_interleave_i;
	a_mon_gate: assert property (
		mon_sync_o && sy |-> reg_rdata_o[7] && reg_rdata_o[0])
		else $error("monitor sync passed while gated");
	a_div_gate: assert property (
		div_sync_o && sy |-> reg_rdata_o[1] && reg_rdata_o[0])
		else $error("divider sync passed while gated");
	a_master_off: assert property (
		sy && !reg_rdata_o[0] |-> !mon_sync_o && !div_sync_o)
		else $error("sync passed with master clear");
	a_div_clear: assert property (
		div_sync_o && sy && reg_rdata_o[2] ##1 sy |-> !reg_rdata_o[1])
		else $error("divider gate not cleared after sync");
	// two cycles allowed for a registered enable
	a_fd_off: assert property (
		(fs && !reg_rdata_o[0])[*2] |-> fd_oe_n_o)
		else $error("fast detect driven while disabled");
	a_fd_both_off: assert property (
		(il && chan_a_off_i && chan_b_off_i)[*3] |-> fd_oe_n_o)
		else $error("fast detect driven with both channels off");
	a_fd_repeat: assert property (
		(il && chan_a_off_i && !chan_b_off_i && $stable(fd_b_i))[*3]
		##0 !fd_oe_n_o |-> fd_a_o == fd_b_i)
		else $error("inactive slot not repeating active data");
	a_ro_keep: assert property (
		reg_wr_i && reg_addr_i == sigmon_regs_pkg::ADDR_RES_A0 ##1
		reg_addr_i == sigmon_regs_pkg::ADDR_RES_A0 |->
		reg_rdata_o == result_a_i[7:0])
		else $error("read-only result changed by write");
	c_div_sync: cover property (div_sync_o && sy);
	c_repeat: cover property (il && chan_a_off_i && !fd_oe_n_o);
	c_ro_wr: cover property (reg_wr_i && reg_addr_i[4]);
endmodule : sigmon_regs_checker

bind sigmon_regs sigmon_regs_checker u_chk (.clk_sys_i, .rst_i,
	.reg_addr_i, .reg_wr_i, .reg_rdata_o, .mon_sync_o, .div_sync_o,
	.result_a_i, .lvds_mode_i, .fd_interleave_i, .chan_a_off_i,
	.chan_b_off_i, .fd_b_i, .fd_a_o, .fd_oe_n_o);

// ==== tb/sigmon_host_model.sv ====
// host side of the register port
module sigmon_host_model (
	// clock and register port
	input  wire logic       clk_sys_i,
	output logic [8:0]      reg_addr_o,
	output logic            reg_wr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr_o = 9'h000;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// one strobe, taken at the next edge
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = v;
		reg_wr_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~v; // stale data must not look valid
	endtask : wr
	// address left in place so readback stays visible
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		#1;
		reg_addr_o = a;
		@(posedge clk_sys_i);
		v = reg_rdata_i;
	endtask : rd
endmodule : sigmon_host_model

// ==== tb/sigmon_regs_tb.sv ====
module sigmon_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic sync_pin_i = 1'b0;
	logic lvds_mode_i = 1'b1, fd_interleave_i = 1'b1;
	logic chan_a_off_i = 1'b0, chan_b_off_i = 1'b0;
	logic [19:0] result_a_i = 20'habcde, result_b_i = 20'h12345;
	logic [13:0] dc_a_i = 14'h3abc, dc_b_i = 14'h1234;
	logic [3:0] fd_a_i = 4'h3, fd_b_i = 4'hc, fd_a_o, fd_b_o, ser_div_o;
	logic [8:0] reg_addr_i, a;
	logic [7:0] reg_wdata_i, reg_rdata_o, d;
	logic reg_wr_i, mon_sync_o, div_sync_o, fd_oe_n_o, mon_ms_o;
	logic mon_en_o, mon_cplx_o, ser_sleep_o;
	logic [3:0] ser_out_en_o;
	logic [23:0] period_o;
	logic [2:0] fd_mode_o, coarse_code_o;
	sigmon_regs_pkg::mon_mode_t mon_mode_o;
	logic [63:0] rv = 64'h0000400004000000, mk = 64'hffffff8f7f070f87;
	logic [7:0] sv [4] = '{8'h00, 8'h86, 8'h83, 8'h87};
	logic [7:0] em [4] = '{8'h00, 8'h00, 8'h02, 8'h02};
	logic [7:0] ed [4] = '{8'h00, 8'h00, 8'h02, 8'h01};
	logic [7:0] er [4] = '{8'h00, 8'h86, 8'h83, 8'h85};
	int err_total = 0, cmp_count = 0, n_mon = 0, n_div = 0, cyc = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	sigmon_host_model u_host (.clk_sys_i, .reg_addr_o(reg_addr_i),
		.reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
		.reg_rdata_i(reg_rdata_o));
	sigmon_regs u_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rdata_o, .sync_pin_i, .mon_sync_o, .div_sync_o,
		.result_a_i, .result_b_i, .dc_a_i, .dc_b_i, .lvds_mode_i,
		.fd_interleave_i, .chan_a_off_i, .chan_b_off_i, .fd_a_i, .fd_b_i,
		.fd_a_o, .fd_b_o, .fd_oe_n_o, .fd_mode_o, .coarse_code_o,
		.period_o, .mon_en_o, .mon_mode_o, .mon_ms_o, .mon_cplx_o,
		.ser_out_en_o, .ser_sleep_o, .ser_div_o);
	// pulse counters and hang guard
	always @(posedge clk_sys_i) begin
		n_mon += (mon_sync_o === 1'b1);
		n_div += (div_sync_o === 1'b1);
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// long high phase so the synchroniser cannot miss the edge
	task automatic pulse();
		@(posedge clk_sys_i);
		#1;
		sync_pin_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1;
		sync_pin_i = 1'b0;
		repeat (6) @(posedge clk_sys_i);
	endtask : pulse
	initial begin
		repeat (3) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		u_host.rd(9'h101, d);
		chk("unmapped", d, 8'h00);
		for (int i = 0; i < 8; i++) begin
			a = i < 3 ? 9'(i == 0 ? 9'h100 : 9'h103 + i) : 9'(9'h10e + i);
			u_host.rd(a, d);
			chk("reset_val", d, rv[8*i +: 8]);
			u_host.wr(a, 8'hff);
			u_host.rd(a, d);
			chk("rw_mask", d, mk[8*i +: 8]);
		end
		chk("fd_mode", {5'h0, fd_mode_o}, 8'h07);
		chk("coarse", {5'h0, coarse_code_o}, 8'h07);
		chk("ser_out_en", {4'h0, ser_out_en_o}, 8'h0f);
		chk("ser_sleep", {7'h0, ser_sleep_o}, 8'h01);
		chk("mon_en_cplx", {6'h0, mon_cplx_o, mon_en_o}, 8'h03);
		for (int i = 0; i < 3; i++)
			u_host.wr(9'(9'h113 + i), i == 0 ? 8'h80 : 8'h00);
		chk("period_lo", period_o[7:0], 8'h80);
		chk("period_hi", period_o[23:16], 8'h00);
		$display("done: reset and access");
		for (int i = 0; i < 4; i++) begin
			u_host.wr(sigmon_regs_pkg::ADDR_SER_CTRL, 8'(i << 2));
			u_host.wr(sigmon_regs_pkg::ADDR_MON_CTRL, {4'h0, i[0], i[1:0], 1'b0});
			chk("ser_div", {4'h0, ser_div_o}, i == 0 ? 8'h02 : 8'(1 << i));
			chk("mon_mode", {6'h0, mon_mode_o}, 8'(i));
			chk("mon_ms", {7'h0, mon_ms_o}, {7'h0, i[0]});
		end
		$display("done: modes");
		for (int i = 0; i < 10; i++) begin
			a = 9'(i < 4 ? 9'h10d + i : 9'h112 + i);
			u_host.wr(a, 8'h5a);
			u_host.rd(a, d);
			chk("read_only", d, 8'({4'h0, result_b_i, 4'h0, result_a_i,
				2'h0, dc_b_i, 2'h0, dc_a_i} >> 8*i));
		end
		$display("done: read-only");
		foreach (sv[i]) begin
			u_host.wr(sigmon_regs_pkg::ADDR_SYNC, sv[i]);
			u_host.rd(sigmon_regs_pkg::ADDR_SYNC, d);
			n_mon = 0;
			n_div = 0;
			repeat (2) pulse();
			u_host.rd(sigmon_regs_pkg::ADDR_SYNC, d);
			chk("mon_pulses", 8'(n_mon), em[i]);
			chk("div_pulses", 8'(n_div), ed[i]);
			chk("sync_reg", d, er[i]);
		end
		$display("done: sync");
		u_host.wr(sigmon_regs_pkg::ADDR_FD_CTRL, 8'h01);
		for (int i = 0; i < 4; i++) begin
			{chan_b_off_i, chan_a_off_i} = 2'(i);
			repeat (3) @(posedge clk_sys_i);
			#1;
			chk("fd_oe_n", {7'h0, fd_oe_n_o}, 8'(i == 3));
			if (i < 3) begin
				chk("fd_a", {4'h0, fd_a_o}, i == 1 ? 8'h0c : 8'h03);
				chk("fd_b", {4'h0, fd_b_o}, i == 2 ? 8'h03 : 8'h0c);
			end
		end
		chan_a_off_i = 1'b0;
		u_host.wr(sigmon_regs_pkg::ADDR_FD_CTRL, 8'h00);
		@(posedge clk_sys_i);
		#1;
		chk("fd_disabled", {7'h0, fd_oe_n_o}, 8'h01);
		$display("done: fast detect");
		print_verdict();
	end
endmodule : sigmon_regs_tb
